// [rtl/tmpf_regs.svh]
// Constants of the tunnel mode packet filter
`ifndef TMPF_REGS_SVH
`define TMPF_REGS_SVH

`define TMPF_MODE_OOB    8'h00
`define TMPF_MODE_GW     8'h01
`define TMPF_MODE_ONEWAY 8'h02
`define TMPF_ERR_LEN     8'h00
`define TMPF_MAX_ADDR    8'h08
`define TMPF_HDR_LAST    3'h5
`define TMPF_SER_LAST    4'h7

`define TMPF_OFS_MODE    12'h000
`define TMPF_OFS_COUNT   12'h004
`define TMPF_OFS_STRIP   12'h008
`define TMPF_OFS_SEL     12'h00C
`define TMPF_OFS_ADDR_HI 12'h010
`define TMPF_OFS_ADDR_LO 12'h014
`define TMPF_OFS_CTRL    12'h018
`define TMPF_OFS_ISTAT   12'h01C
`define TMPF_OFS_IMASK   12'h020
`define TMPF_OFS_LAST    12'h024

`define TMPF_ST_LEN      0
`define TMPF_ST_UNDEF    1
`define TMPF_ST_DENY     2
`define TMPF_ST_DONE     3
`define TMPF_CTRL_COMMIT 0
`define TMPF_CTRL_PEND   8

`endif

// [rtl/tmpf_pkg.sv]
// Types of the tunnel mode packet filter
package tmpf_pkg;
    typedef enum logic [6:0] {
        TMPF_IDLE  = 7'b000_0001,
        TMPF_HEAD  = 7'b000_0010,
        TMPF_MATCH = 7'b000_0100,
        TMPF_CMP   = 7'b000_1000,
        TMPF_EMIT  = 7'b001_0000,
        TMPF_BODY  = 7'b010_0000,
        TMPF_DROP  = 7'b100_0000
    } tmpf_state_t;

    typedef struct packed {
        logic [15:0][47:0] mem;
        logic [47:0]       rdata;
    } tmpf_mem_t;

    typedef struct packed {
        tmpf_state_t st;
        logic [7:0]  mode;
        logic [3:0]  cnt;
        logic [15:0] strip;
        logic        bank;
        logic [7:0]  stg_mode;
        logic [7:0]  stg_cnt;
        logic [15:0] stg_strip;
        logic        pend;
        logic [2:0]  sel;
        logic [15:0] addr_hi;
        logic [47:0] hdr;
        logic [2:0]  hcnt;
        logic [2:0]  idx;
        logic        got_last;
        logic [15:0] pos;
        logic [15:0] fcnt;
        logic [15:0] last_cnt;
        logic [7:0]  sh;
        logic [3:0]  bitcnt;
        logic        drx_data;
        logic        drx_valid;
        logic        pkt_ready;
        logic        tune_valid;
        logic        tune_busy;
        logic        oob_tx_en;
        logic        cm_tx_en;
        logic [3:0]  ist;
        logic [3:0]  imask;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tmpf_top_t;
endpackage

// [rtl/tmpf_addr_mem.sv]
// Two-bank tunnel address store with registered read
`timescale 1ns/10ps
module tmpf_addr_mem (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Write port
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [47:0] wdata,
    // Read port
    input  wire logic [3:0]  raddr,
    output logic      [47:0] rdata
);
    import tmpf_pkg::*;

    tmpf_mem_t s;
    tmpf_mem_t next_s;

    always_comb begin
        next_s = s;
        if (we) begin
            next_s.mem[waddr] = wdata;
        end
        next_s.rdata = s.mem[raddr];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
endmodule

// [rtl/tmpf_top.sv]
// Mode control and tunnel packet filter with serial output
`timescale 1ns/10ps
`include "tmpf_regs.svh"
module tmpf_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    // Incoming frame bytes
    input  wire logic        pkt_valid,
    input  wire logic [7:0]  pkt_data,
    input  wire logic        pkt_last,
    output logic             pkt_ready,
    // Serial receive data toward the module
    output logic             serial_receive_data_pin,
    output logic             serial_receive_data_valid,
    // Transmitter tune requests from the module
    input  wire logic        transmitter_tune_request,
    output logic             tune_resp_valid,
    output logic             tune_resp_busy,
    // Return transmitter enables
    output logic             oob_tx_enable,
    output logic             cm_tx_enable,
    // Error reports from the module
    input  wire logic        err_valid,
    input  wire logic [7:0]  err_code,
    // Interrupt
    output logic             irq
);
    import tmpf_pkg::*;

    tmpf_top_t   s;
    tmpf_top_t   next_s;
    logic [47:0] mem_rdata;
    logic        mem_we;
    logic [3:0]  mem_raddr;
    logic        accept;
    logic        ser_load;
    logic        apply;
    logic [7:0]  load_byte;

    function automatic logic is_tunnel(input logic [7:0] m);
        is_tunnel = (m == `TMPF_MODE_GW) || (m == `TMPF_MODE_ONEWAY);
    endfunction

    function automatic logic mode_valid(input logic [7:0] m);
        mode_valid = (m == `TMPF_MODE_OOB) || is_tunnel(m);
    endfunction

    tmpf_addr_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (mem_we),
        .waddr   ({~s.bank, s.sel}),
        .wdata   ({s.addr_hi, pwdata}),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    always_comb begin
        logic        setup;
        logic        wr;
        logic [3:0]  set_st;
        logic [3:0]  clr_st;
        logic [31:0] rd;
        logic        err;
        logic        done;
        setup     = psel && !penable;
        wr        = psel && penable && s.pready && pwrite;
        set_st    = 4'h0;
        clr_st    = 4'h0;
        rd        = 32'h0000_0000;
        err       = 1'b0;
        done      = 1'b0;
        next_s    = s;
        accept    = pkt_valid && s.pkt_ready;
        ser_load  = 1'b0;
        load_byte = 8'h00;
        apply     = 1'b0;
        mem_we    = wr && (paddr == `TMPF_OFS_ADDR_LO);
        mem_raddr = {s.bank, s.idx};

        // Register bus: answer one cycle after setup, no wait states
        next_s.pready = setup;
        if (setup) begin
            case (paddr)
                `TMPF_OFS_MODE:    rd[7:0] = s.stg_mode;
                `TMPF_OFS_COUNT:   rd[7:0] = s.stg_cnt;
                `TMPF_OFS_STRIP:   rd[15:0] = s.stg_strip;
                `TMPF_OFS_SEL:     rd[2:0] = s.sel;
                `TMPF_OFS_ADDR_HI: rd[15:0] = s.addr_hi;
                `TMPF_OFS_ADDR_LO: rd = 32'h0000_0000;
                `TMPF_OFS_CTRL:    rd[`TMPF_CTRL_PEND:0] = {s.pend, s.mode};
                `TMPF_OFS_ISTAT:   rd[3:0] = s.ist;
                `TMPF_OFS_IMASK:   rd[3:0] = s.imask;
                `TMPF_OFS_LAST:    rd[15:0] = s.last_cnt;
                default:           err = 1'b1;
            endcase
            next_s.prdata  = rd;
            next_s.pslverr = err;
        end
        if (wr) begin
            case (paddr)
                `TMPF_OFS_MODE:    next_s.stg_mode = pwdata[7:0];
                `TMPF_OFS_COUNT:   next_s.stg_cnt = pwdata[7:0];
                `TMPF_OFS_STRIP:   next_s.stg_strip = pwdata[15:0];
                `TMPF_OFS_SEL:     next_s.sel = pwdata[2:0];
                `TMPF_OFS_ADDR_HI: next_s.addr_hi = pwdata[15:0];
                `TMPF_OFS_ISTAT:   clr_st = pwdata[3:0];
                `TMPF_OFS_IMASK:   next_s.imask = pwdata[3:0];
                default: begin
                end
            endcase
        end

        // Tune requests: only out-of-band mode lets the module steer the transmitter
        next_s.tune_valid = transmitter_tune_request;
        if (transmitter_tune_request) begin
            next_s.tune_busy = (s.mode != `TMPF_MODE_OOB);
            set_st[`TMPF_ST_DENY] = (s.mode != `TMPF_MODE_OOB);
        end
        next_s.oob_tx_en = (s.mode == `TMPF_MODE_OOB);
        next_s.cm_tx_en  = (s.mode == `TMPF_MODE_GW);

        if (err_valid) begin
            set_st[`TMPF_ST_LEN]   = (err_code == `TMPF_ERR_LEN);
            set_st[`TMPF_ST_UNDEF] = (err_code != `TMPF_ERR_LEN);
        end

        // Serializer, MSB first, back to back bytes without gaps
        if (s.bitcnt != 4'h0) begin
            next_s.drx_data  = s.sh[7];
            next_s.sh        = {s.sh[6:0], 1'b0};
            next_s.bitcnt    = s.bitcnt - 4'h1;
            next_s.drx_valid = 1'b1;
        end else begin
            next_s.drx_valid = 1'b0;
        end

        case (s.st)
            TMPF_IDLE: begin
                next_s.pos  = 16'h0000;
                next_s.fcnt = 16'h0000;
                next_s.hcnt = 3'h0;
                if (accept) begin
                    next_s.pos = 16'h0001;
                    next_s.hdr = {s.hdr[39:0], pkt_data};
                    if (!is_tunnel(s.mode)) begin
                        next_s.st = pkt_last ? TMPF_IDLE : TMPF_DROP;
                    end else if (!pkt_last) begin
                        next_s.hcnt = 3'h1;
                        next_s.st   = TMPF_HEAD;
                    end
                end else if (s.pend && !s.pkt_ready) begin
                    apply = 1'b1;
                end
                // A frame that starts while a commit waits must keep its ready, or the header stalls
                next_s.pkt_ready = !(s.pend && !apply) || accept;
            end
            TMPF_HEAD: begin
                if (accept) begin
                    next_s.hdr  = {s.hdr[39:0], pkt_data};
                    next_s.pos  = s.pos + 16'h0001;
                    next_s.hcnt = s.hcnt + 3'h1;
                    if (s.hcnt == `TMPF_HDR_LAST) begin
                        next_s.got_last  = pkt_last;
                        next_s.idx       = 3'h0;
                        next_s.pkt_ready = 1'b0;
                        next_s.st        = TMPF_MATCH;
                        if (s.cnt == 4'h0) begin
                            next_s.pkt_ready = !pkt_last;
                            next_s.st        = pkt_last ? TMPF_IDLE : TMPF_DROP;
                        end
                    end else if (pkt_last) begin
                        // Runt frame without a full destination address
                        next_s.st = TMPF_IDLE;
                    end
                end
            end
            TMPF_MATCH: begin
                next_s.st = TMPF_CMP;
            end
            TMPF_CMP: begin
                // Sequential search trades a few cycles per frame for one narrow RAM
                if (mem_rdata == s.hdr) begin
                    next_s.idx = 3'h0;
                    next_s.st  = TMPF_EMIT;
                end else if ({1'b0, s.idx} + 4'h1 < s.cnt) begin
                    next_s.idx = s.idx + 3'h1;
                    next_s.st  = TMPF_MATCH;
                end else begin
                    next_s.pkt_ready = !s.got_last;
                    next_s.st        = s.got_last ? TMPF_IDLE : TMPF_DROP;
                end
            end
            TMPF_EMIT: begin
                // Replay the held destination address bytes through the strip filter
                if ({13'h0000, s.idx} < s.strip) begin
                    next_s.idx = s.idx + 3'h1;
                    next_s.hdr = {s.hdr[39:0], 8'h00};
                end else if (s.bitcnt == 4'h0) begin
                    ser_load    = 1'b1;
                    load_byte   = s.hdr[47:40];
                    next_s.fcnt = s.fcnt + 16'h0001;
                    next_s.idx  = s.idx + 3'h1;
                    next_s.hdr  = {s.hdr[39:0], 8'h00};
                end
                if (next_s.idx > `TMPF_HDR_LAST) begin
                    next_s.st = s.got_last ? TMPF_IDLE : TMPF_BODY;
                    done      = s.got_last;
                end
            end
            TMPF_BODY: begin
                if (accept) begin
                    next_s.pos = (s.pos == 16'hFFFF) ? s.pos : s.pos + 16'h0001;
                    if (s.pos >= s.strip) begin
                        ser_load    = 1'b1;
                        load_byte   = pkt_data;
                        next_s.fcnt = s.fcnt + 16'h0001;
                    end
                    if (pkt_last) begin
                        next_s.st = TMPF_IDLE;
                        done      = 1'b1;
                    end
                end
            end
            TMPF_DROP: begin
                next_s.pkt_ready = 1'b1;
                if (accept && pkt_last) begin
                    next_s.st = TMPF_IDLE;
                end
            end
            default: begin
                next_s.st = TMPF_IDLE;
            end
        endcase

        if (ser_load) begin
            next_s.drx_data  = load_byte[7];
            next_s.sh        = {load_byte[6:0], 1'b0};
            next_s.bitcnt    = `TMPF_SER_LAST;
            next_s.drx_valid = 1'b1;
        end
        if (next_s.st == TMPF_BODY) begin
            // Ready only when the serializer can take the next byte at once
            next_s.pkt_ready = (next_s.bitcnt == 4'h0);
        end
        if (done) begin
            next_s.last_cnt        = next_s.fcnt;
            set_st[`TMPF_ST_DONE]  = 1'b1;
        end

        // Configuration swap; a commit in the same cycle stays pending
        if (apply) begin
            next_s.pend = 1'b0;
            next_s.mode = s.stg_mode;
            if (is_tunnel(s.stg_mode)) begin
                next_s.cnt   = (s.stg_cnt > `TMPF_MAX_ADDR) ? 4'(`TMPF_MAX_ADDR) : s.stg_cnt[3:0];
                next_s.strip = s.stg_strip;
                next_s.bank  = ~s.bank;
            end
        end
        if (wr && paddr == `TMPF_OFS_CTRL && pwdata[`TMPF_CTRL_COMMIT] && mode_valid(s.stg_mode)) begin
            next_s.pend = 1'b1;
        end

        next_s.ist = (s.ist & ~clr_st) | set_st;
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.st       <= TMPF_IDLE;
            s.mode     <= `TMPF_MODE_OOB;
            s.stg_mode <= `TMPF_MODE_OOB;
        end else begin
            s <= next_s;
        end
    end

    assign pready                    = s.pready;
    assign pslverr                   = s.pslverr;
    assign prdata                    = s.prdata;
    assign pkt_ready                 = s.pkt_ready;
    assign serial_receive_data_pin   = s.drx_data;
    assign serial_receive_data_valid = s.drx_valid;
    assign tune_resp_valid           = s.tune_valid;
    assign tune_resp_busy            = s.tune_busy;
    assign oob_tx_enable             = s.oob_tx_en;
    assign cm_tx_enable              = s.cm_tx_en;
    assign irq                       = s.irq;

    sequence s_load;
        ser_load;
    endsequence
    sequence s_eight_bits;
        s.drx_valid [*8];
    endsequence
    property p_serial_byte;
        @(posedge pclk) disable iff (!presetn) s_load |=> s_eight_bits;
    endproperty

    a_tune_gw_busy: assert property (@(posedge pclk) disable iff (!presetn)
        transmitter_tune_request && s.mode == `TMPF_MODE_GW |=> tune_resp_valid && tune_resp_busy)
        else $error("tune request granted in gateway mode");
    a_oneway_tx_off: assert property (@(posedge pclk) disable iff (!presetn)
        s.mode == `TMPF_MODE_ONEWAY |=> !oob_tx_enable && !cm_tx_enable)
        else $error("transmitter enabled in receive-only mode");
    a_mode_held: assert property (@(posedge pclk) disable iff (!presetn)
        !apply |=> s.mode == $past(s.mode))
        else $error("mode changed without an announcement");
    a_count_cap: assert property (@(posedge pclk) disable iff (!presetn)
        s.cnt <= 4'h8)
        else $error("address count above eight");
    a_oob_drop: assert property (@(posedge pclk) disable iff (!presetn)
        s.st == TMPF_IDLE && accept && !is_tunnel(s.mode) |=> !s.drx_valid && s.st != TMPF_HEAD)
        else $error("frame taken in out-of-band mode");
    a_strip_honour: assert property (@(posedge pclk) disable iff (!presetn)
        ser_load && s.st == TMPF_BODY |-> s.pos >= s.strip)
        else $error("header byte forwarded despite strip count");
    a_serial_byte: assert property (p_serial_byte)
        else $error("serial byte shorter than eight bits");
    a_swap_boundary: assert property (@(posedge pclk) disable iff (!presetn)
        s.pend && s.st != TMPF_IDLE |=> s.mode == $past(s.mode) && s.bank == $past(s.bank))
        else $error("configuration swapped inside a frame");
    a_len_flag: assert property (@(posedge pclk) disable iff (!presetn)
        err_valid && err_code == `TMPF_ERR_LEN |=> s.ist[`TMPF_ST_LEN] ##1 irq || !s.imask[`TMPF_ST_LEN])
        else $error("length mismatch not flagged");
endmodule

// [dv/tmpf_cam_model.sv]
// Behavioural model of the removable module on the far side of the filter
`timescale 1ns/10ps
module tmpf_cam (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Serial stream from the host
    input  wire logic       serial_receive_data_pin,
    input  wire logic       serial_receive_data_valid,
    // Requests and reports toward the host
    output logic            transmitter_tune_request,
    output logic            err_valid,
    output logic      [7:0] err_code
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    int         nbit;

    initial begin
        transmitter_tune_request = 1'b0;
        err_valid = 1'b0;
        err_code = 8'h00;
    end

    // Bits arrive most significant first, eight per byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nbit = 0;
            rx_q.delete();
        end else if (serial_receive_data_valid === 1'b1) begin
            sh = {sh[6:0], serial_receive_data_pin};
            nbit = nbit + 1;
            if (nbit == 8) begin
                rx_q.push_back(sh);
                nbit = 0;
            end
        end
    end

    task automatic pulse_tune();
        @(posedge pclk);
        transmitter_tune_request <= 1'b1;
        @(posedge pclk);
        transmitter_tune_request <= 1'b0;
    endtask

    // Code is only meaningful with the strobe, so it is scrambled afterwards
    task automatic report(input logic [7:0] code);
        @(posedge pclk);
        err_valid <= 1'b1;
        err_code <= code;
        @(posedge pclk);
        err_valid <= 1'b0;
        err_code <= ~code;
    endtask

    // Compare what arrived against the count the host signalled
    task automatic check_count(input int signalled);
        if (rx_q.size() != signalled) begin
            report(8'h00);
        end
        rx_q.delete();
    endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the tunnel mode packet filter
`timescale 1ns/10ps
`include "tmpf_regs.svh"
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        pkt_valid;
    logic [7:0]  pkt_data;
    logic        pkt_last;
    logic        pkt_ready;
    logic        sdata;
    logic        svalid;
    logic        tune_req;
    logic        tune_valid;
    logic        tune_busy;
    logic        oob_en;
    logic        cm_en;
    logic        err_valid;
    logic [7:0]  err_code;
    logic        irq;
    logic [31:0] rd;
    logic        rerr;
    logic [7:0]  frm[$];
    int          errors;
    int          total_checks;
    logic [47:0] addr_tab [3] = '{48'h0200_1122_3344, 48'h0200_5566_7788, 48'h0200_99AA_BBCC};

    tmpf_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
        .serial_receive_data_pin(sdata), .serial_receive_data_valid(svalid),
        .transmitter_tune_request(tune_req), .tune_resp_valid(tune_valid), .tune_resp_busy(tune_busy),
        .oob_tx_enable(oob_en), .cm_tx_enable(cm_en), .err_valid(err_valid), .err_code(err_code), .irq(irq)
    );

    tmpf_cam u_cam (
        .pclk(pclk), .presetn(presetn), .serial_receive_data_pin(sdata),
        .serial_receive_data_valid(svalid), .transmitter_tune_request(tune_req),
        .err_valid(err_valid), .err_code(err_code)
    );

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    task automatic final_report();
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Request is held until pready is seen high, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            final_report();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Frame is the address bytes then a counting payload; waits for the line to go quiet
    task automatic send(input logic [47:0] da, input int n);
        int k;
        int q;
        frm.delete();
        for (int i = 0; i < n; i++)
            frm.push_back(i < 6 ? da[47-8*i -: 8] : 8'hA0 + 8'(i));
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            pkt_valid <= 1'b1;
            pkt_data <= frm[i];
            pkt_last <= (i == n - 1);
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (pkt_ready !== 1'b1 && k < 200);
            if (k >= 200) begin
                errors++;
                final_report();
            end
        end
        pkt_valid <= 1'b0;
        pkt_last <= 1'b0;
        pkt_data <= ~frm[n-1];
        k = 0;
        q = 0;
        while (q < 30 && k < 600) begin
            @(posedge pclk);
            k++;
            q = (svalid === 1'b1) ? 0 : q + 1;
        end
        if (q < 30) begin
            errors++;
            final_report();
        end
    endtask

    // Received bytes must be the frame minus its leading strip bytes
    task automatic chk_rx(input int strip, input int bad);
        chk("rx_len", 32'(u_cam.rx_q.size()), 32'(frm.size() - strip));
        for (int i = 0; i < u_cam.rx_q.size(); i++)
            chk("rx_byte", 32'(u_cam.rx_q[i]), 32'(frm[i + strip]));
        u_cam.check_count(frm.size() - strip + bad);
    endtask

    task automatic cfg(input logic [7:0] mode, input logic [7:0] cnt, input logic [15:0] strip);
        apb(1'b1, `TMPF_OFS_MODE, 32'(mode));
        if (mode == `TMPF_MODE_GW || mode == `TMPF_MODE_ONEWAY) begin
            apb(1'b1, `TMPF_OFS_COUNT, 32'(cnt));
            apb(1'b1, `TMPF_OFS_STRIP, 32'(strip));
            for (int i = 0; i < 3; i++) begin
                apb(1'b1, `TMPF_OFS_SEL, 32'(i));
                apb(1'b1, `TMPF_OFS_ADDR_HI, 32'(addr_tab[i][47:32]));
                apb(1'b1, `TMPF_OFS_ADDR_LO, addr_tab[i][31:0]);
            end
        end
        apb(1'b1, `TMPF_OFS_CTRL, 32'h0000_0001);
        for (int k = 0; k < 10; k++) begin
            apb(1'b0, `TMPF_OFS_CTRL, 32'h0000_0000);
            if (rd[8] === 1'b0) break;
        end
        chk("commit_done", 32'(rd[8]), 32'h0000_0000);
        chk("mode", 32'(rd[7:0]), 32'(mode));
    endtask

    task automatic t_reset();
        repeat (3) @(posedge pclk);
        chk("oob_en", 32'(oob_en), 32'h0000_0001);
        apb(1'b0, `TMPF_OFS_CTRL, 32'h0000_0000);
        chk("mode_rst", 32'(rd[7:0]), 32'(`TMPF_MODE_OOB));
        u_cam.pulse_tune();
        @(posedge pclk);
        chk("tune_oob", 32'({tune_valid, tune_busy}), 32'h0000_0002);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk("unmapped_err", 32'(rerr), 32'h0000_0001);
    endtask

    task automatic t_gateway();
        cfg(`TMPF_MODE_GW, 8'h02, 16'h0000);
        chk("tx_gw", 32'({oob_en, cm_en}), 32'h0000_0001);
        u_cam.pulse_tune();
        @(posedge pclk);
        chk("tune_gw", 32'({tune_valid, tune_busy}), 32'h0000_0003);
        send(addr_tab[1], 10);
        chk_rx(0, 0);
        apb(1'b0, `TMPF_OFS_LAST, 32'h0000_0000);
        chk("last_count", rd, 32'h0000_000A);
        send(addr_tab[2], 8);
        chk_rx(8, 0);
        send(48'h0200_0000_0001, 8);
        chk_rx(8, 0);
        apb(1'b0, `TMPF_OFS_ISTAT, 32'h0000_0000);
        chk("istat_gw", 32'(rd[3:0]), 32'h0000_000C);
        apb(1'b1, `TMPF_OFS_ISTAT, 32'h0000_000F);
    endtask

    // Host deliberately signals a wrong count to provoke a length report
    task automatic t_oneway();
        cfg(`TMPF_MODE_ONEWAY, 8'h03, 16'h0003);
        chk("tx_off", 32'({oob_en, cm_en}), 32'h0000_0000);
        u_cam.pulse_tune();
        @(posedge pclk);
        chk("tune_ow", 32'({tune_valid, tune_busy}), 32'h0000_0003);
        apb(1'b1, `TMPF_OFS_IMASK, 32'h0000_0003);
        send(addr_tab[2], 10);
        chk_rx(3, 1);
        apb(1'b0, `TMPF_OFS_ISTAT, 32'h0000_0000);
        chk("istat_len", 32'(rd[1:0]), 32'h0000_0001);
        chk("irq_on", 32'(irq), 32'h0000_0001);
        u_cam.report(8'h5A);
        apb(1'b0, `TMPF_OFS_ISTAT, 32'h0000_0000);
        chk("istat_undef", 32'(rd[1:0]), 32'h0000_0003);
        apb(1'b1, `TMPF_OFS_ISTAT, 32'h0000_000F);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'(irq), 32'h0000_0000);
        apb(1'b1, `TMPF_OFS_MODE, 32'h0000_0003);
        apb(1'b1, `TMPF_OFS_CTRL, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        apb(1'b0, `TMPF_OFS_CTRL, 32'h0000_0000);
        chk("mode_rsvd", 32'(rd[7:0]), 32'(`TMPF_MODE_ONEWAY));
    endtask

    task automatic t_oob();
        cfg(`TMPF_MODE_OOB, 8'h03, 16'h0000);
        send(addr_tab[0], 10);
        chk_rx(10, 0);
    endtask

    initial begin
        errors = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pkt_valid = 1'b0;
        pkt_data = 8'h00;
        pkt_last = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gateway();
        t_oneway();
        t_oob();
        final_report();
    end

    // Hang guard at 100000 cycles, well beyond the whole run
    initial begin
        #500000;
        errors++;
        final_report();
    end
endmodule
